//--- hw/cob_decode_map.vh
/*
  Constants for the identifier and object-index decode block: identifier
  fields, function codes, index area bounds, payload size and timing.
  Assumes inclusion by the design files only; holds definitions only.
*/
`ifndef COB_DECODE_MAP_VH
`define COB_DECODE_MAP_VH

// ----------------------------------------
// Identifier layout
// ----------------------------------------
`define ID_WIDTH 11
`define NODE_MSB 6
`define FUNC_MSB 10
`define FUNC_LSB 7
`define SDO_TX_BASE 11'h580
`define SDO_RX_BASE 11'h600
`define FUNC_SDO_RX 4'hC

// ----------------------------------------
// Object directory areas
// ----------------------------------------
`define AREA_NONE 3'h0
`define AREA_COMM 3'h1
`define AREA_MFR 3'h2
`define AREA_DEVICE 3'h3
`define AREA_IFACE 3'h4
`define AREA_RSVD 3'h5
`define IDX_COMM_LO 16'h0001
`define IDX_COMM_HI 16'h1FFF
`define IDX_DEV_LO 16'h6000
`define IDX_DEV_HI 16'h9FFF
`define IDX_IF_LO 16'hA000
`define IDX_IF_HI 16'hBFFF
`define IDX_TARGET_POS 16'h607A

// ----------------------------------------
// Payload, timing and receive buffer size
// ----------------------------------------
`define MAX_BYTES 4'h8
`define INHIBIT_UNIT_US 100
`define CLOCK_MHZ 10
`define INHIBIT_UNIT_CYC (`INHIBIT_UNIT_US * `CLOCK_MHZ)
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

//--- hw/frame_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides, used for received frames.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module frame_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Handshake terms
  assign in_ready_out = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage write
  always @(posedge clock_in) begin
    if (push) begin
      mem[wr_reg] <= in_data_in;
    end
  end

  // Pointers and fill count
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- hw/cob_id_decode.v
/*
  Identifier and object-index decode for a field-bus drive node.
  Receive side: filters frames by node address, buffers accepted frames,
  decodes the object index of service requests into directory areas.
  Transmit side: arbitrates by identifier, packs a 32-bit value LSB first,
  and enforces a per-slot inhibit interval. Assumes a CAN controller
  outside that moves whole frames with a ready/valid handshake.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cob_decode_map.vh"

module cob_id_decode (
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Switch settings
  input wire [6:0] node_sw_in,
  input wire [2:0] rate_sw_in,
  // Received frame from controller
  input wire rx_valid_in,
  input wire [10:0] rx_id_in,
  input wire rx_ext_in,
  input wire [3:0] rx_len_in,
  input wire [63:0] rx_data_in,
  output reg rx_ready_out,
  // Decoded received frame
  output reg dec_valid_out,
  input wire dec_ready_in,
  output reg [3:0] dec_func_out,
  output reg [3:0] dec_len_out,
  output reg [63:0] dec_data_out,
  output reg dec_sdo_out,
  output reg [15:0] dec_index_out,
  output reg [2:0] dec_area_out,
  output reg dec_target_out,
  // Transmit requests, two slots
  input wire [1:0] tx_req_in,
  input wire [21:0] tx_id_in,
  input wire [31:0] tx_value0_in,
  input wire [31:0] tx_value1_in,
  input wire [5:0] tx_len_in,
  input wire [15:0] inhibit0_in,
  input wire [15:0] inhibit1_in,
  output reg [1:0] tx_busy_out,
  // Frame to controller
  output reg tx_valid_out,
  input wire tx_ready_in,
  output reg [10:0] tx_id_out,
  output reg [3:0] tx_len_out,
  output reg [63:0] tx_data_out,
  // Fixed settings seen by the rest of the node
  output reg [6:0] node_id_out,
  output reg [2:0] bit_rate_out,
  output reg [10:0] sdo_tx_id_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Directory area of a 16-bit index
  function [2:0] area_of;
    input [15:0] idx;
    begin
      if (idx >= `IDX_COMM_LO && idx <= `IDX_COMM_HI) begin
        area_of = `AREA_COMM;
      end else if (idx >= `IDX_DEV_LO && idx <= `IDX_DEV_HI) begin
        area_of = `AREA_DEVICE;
      end else if (idx >= `IDX_IF_LO && idx <= `IDX_IF_HI) begin
        area_of = `AREA_IFACE;
      end else if (idx == 16'h0000) begin
        area_of = `AREA_NONE;
      end else if (idx < `IDX_DEV_LO) begin
        area_of = `AREA_MFR;
      end else begin
        area_of = `AREA_RSVD;
      end
    end
  endfunction

  // Byte length clipped to the payload size
  function [3:0] clip_len;
    input [3:0] len;
    begin
      clip_len = (len > `MAX_BYTES) ? `MAX_BYTES : len;
    end
  endfunction

  // ----------------------------------------
  // Switch capture
  // ----------------------------------------
  reg started_reg;

  // Switches taken once after reset release, never from the bus
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      started_reg <= 1'b0;
      node_id_out <= 7'h00;
      bit_rate_out <= 3'h0;
      sdo_tx_id_out <= 11'h000;
    end else if (!started_reg) begin
      started_reg <= 1'b1;
      node_id_out <= node_sw_in;
      bit_rate_out <= rate_sw_in;
      sdo_tx_id_out <= `SDO_TX_BASE + {4'h0, node_sw_in};
    end
  end

  // ----------------------------------------
  // Receive filter into FIFO
  // ----------------------------------------
  wire [3:0] rx_func;
  wire [6:0] rx_node;
  wire rx_bcast;
  wire rx_accept;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [72:0] fifo_out_data;
  reg fifo_pop;

  assign rx_func = rx_id_in[`FUNC_MSB:`FUNC_LSB];
  assign rx_node = rx_id_in[`NODE_MSB:0];
  assign rx_bcast = (rx_node == 7'h00);
  // Extended frames and other nodes' frames are dropped
  assign rx_accept = started_reg && !rx_ext_in && (rx_bcast || rx_node == node_id_out);

  // Ready low when full, and for one cycle after each take: a registered
  // ready would otherwise still show the fill count from before the push
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_ready_out <= 1'b0;
    end else begin
      rx_ready_out <= started_reg && fifo_in_ready && !(rx_valid_in && rx_ready_out);
    end
  end

  frame_fifo #(
    .WIDTH(73),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(rx_valid_in && rx_ready_out && rx_accept),
    .in_ready_out(fifo_in_ready),
    .in_data_in({rx_func, clip_len(rx_len_in), rx_data_in,
      rx_id_in == (`SDO_RX_BASE + {4'h0, node_id_out})}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // ----------------------------------------
  // Object index decode
  // ----------------------------------------
  wire [63:0] head_data;
  wire [15:0] head_index;
  wire head_sdo;

  assign head_data = fifo_out_data[64:1];
  // Index sits in payload bytes 1 and 2, low byte first
  assign head_index = {head_data[23:16], head_data[15:8]};
  assign head_sdo = fifo_out_data[0];

  // Output stage: load when empty or being drained
  always @* begin
    fifo_pop = fifo_out_valid && (!dec_valid_out || dec_ready_in);
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dec_valid_out <= 1'b0;
      dec_func_out <= 4'h0;
      dec_len_out <= 4'h0;
      dec_data_out <= 64'h0000000000000000;
      dec_sdo_out <= 1'b0;
      dec_index_out <= 16'h0000;
      dec_area_out <= `AREA_NONE;
      dec_target_out <= 1'b0;
    end else if (fifo_pop) begin
      dec_valid_out <= 1'b1;
      dec_func_out <= fifo_out_data[72:69];
      dec_len_out <= fifo_out_data[68:65];
      dec_data_out <= head_data;
      dec_sdo_out <= head_sdo;
      dec_index_out <= head_sdo ? head_index : 16'h0000;
      dec_area_out <= head_sdo ? area_of(head_index) : `AREA_NONE;
      dec_target_out <= head_sdo && (head_index == `IDX_TARGET_POS);
    end else if (dec_ready_in) begin
      dec_valid_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Inhibit timers, one per slot
  // ----------------------------------------
  reg [9:0] unit_reg;
  reg [15:0] inh0_reg;
  reg [15:0] inh1_reg;
  reg skip0_reg;
  reg skip1_reg;
  wire unit_tick;
  reg [1:0] sent_pulse;

  assign unit_tick = (unit_reg == (`INHIBIT_UNIT_CYC - 1));

  // Inhibit counted in 100 us units, restarted on each send; the partial
  // unit right after a send is skipped so the gap is never short
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      unit_reg <= 10'h000;
      inh0_reg <= 16'h0000;
      inh1_reg <= 16'h0000;
      skip0_reg <= 1'b0;
      skip1_reg <= 1'b0;
    end else begin
      unit_reg <= unit_tick ? 10'h000 : unit_reg + 1'b1;
      if (sent_pulse[0]) begin
        inh0_reg <= inhibit0_in;
        skip0_reg <= (inhibit0_in != 16'h0000);
      end else if (unit_tick && skip0_reg) begin
        skip0_reg <= 1'b0;
      end else if (unit_tick && inh0_reg != 16'h0000) begin
        inh0_reg <= inh0_reg - 1'b1;
      end
      if (sent_pulse[1]) begin
        inh1_reg <= inhibit1_in;
        skip1_reg <= (inhibit1_in != 16'h0000);
      end else if (unit_tick && skip1_reg) begin
        skip1_reg <= 1'b0;
      end else if (unit_tick && inh1_reg != 16'h0000) begin
        inh1_reg <= inh1_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmit arbitration and packing
  // ----------------------------------------
  wire [10:0] id0;
  wire [10:0] id1;
  wire elig0;
  wire elig1;
  wire pick1;
  reg [1:0] pend_reg;

  assign id0 = tx_id_in[10:0];
  assign id1 = tx_id_in[21:11];
  assign elig0 = pend_reg[0] && inh0_reg == 16'h0000;
  assign elig1 = pend_reg[1] && inh1_reg == 16'h0000;
  // Lower identifier wins when both may go
  assign pick1 = elig1 && (!elig0 || id1 < id0);

  always @* begin
    sent_pulse = 2'b00;
    if (tx_valid_out && tx_ready_in) begin
      sent_pulse = tx_busy_out;
    end
  end

  // Pending requests, frame launch and handshake
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg <= 2'b00;
      tx_busy_out <= 2'b00;
      tx_valid_out <= 1'b0;
      tx_id_out <= 11'h000;
      tx_len_out <= 4'h0;
      tx_data_out <= 64'h0000000000000000;
    end else begin
      pend_reg <= (pend_reg | tx_req_in) & ~tx_busy_out & ~sent_pulse;
      if (tx_valid_out) begin
        if (tx_ready_in) begin
          tx_valid_out <= 1'b0;
          tx_busy_out <= 2'b00;
        end
      end else if (elig0 || elig1) begin
        tx_valid_out <= 1'b1;
        tx_busy_out <= pick1 ? 2'b10 : 2'b01;
        tx_id_out <= pick1 ? id1 : id0;
        tx_len_out <= pick1 ? clip_len({1'b0, tx_len_in[5:3]}) :
          clip_len({1'b0, tx_len_in[2:0]});
        // Value bytes low first in bytes 0..3
        tx_data_out <= {32'h00000000, pick1 ? tx_value1_in : tx_value0_in};
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/cob_id_monitor.sv
/*
  Checker for the identifier decode block: handshakes, decode, settings.
  Assumes binding to cob_id_decode and sight of its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module cob_id_monitor (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Decoded frame side
  input wire logic rx_ready_out,
  input wire logic dec_valid_out,
  input wire logic dec_ready_in,
  input wire logic [3:0] dec_func_out,
  input wire logic [3:0] dec_len_out,
  input wire logic [63:0] dec_data_out,
  input wire logic dec_sdo_out,
  input wire logic [15:0] dec_index_out,
  input wire logic [2:0] dec_area_out,
  input wire logic dec_target_out,
  // Transmit side
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [3:0] tx_len_out,
  input wire logic [63:0] tx_data_out,
  // Fixed settings
  input wire logic [6:0] node_id_out,
  input wire logic [2:0] bit_rate_out,
  input wire logic [10:0] sdo_tx_id_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // --------------------------------
  // Frame handshakes and decode
  // --------------------------------
  sequence s_rx_wait; dec_valid_out && !dec_ready_in; endsequence
  sequence s_tx_wait; tx_valid_out && !tx_ready_in; endsequence
  sequence s_sdo; dec_valid_out && dec_sdo_out; endsequence
  property p_rx_hold; s_rx_wait |=> dec_valid_out && $stable(dec_data_out); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("held frame changed");
  property p_tx_hold; s_tx_wait |=> tx_valid_out && $stable(tx_data_out); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("offered frame changed");
  property p_rx_len; dec_valid_out |-> dec_len_out <= 4'h8; endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx length over eight");
  property p_tx_len; tx_valid_out |-> tx_len_out <= 4'h8; endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx length over eight");
  property p_tx_lsb; tx_valid_out |-> tx_data_out[63:32] == 32'h0; endproperty
  a_tx_lsb: assert property (p_tx_lsb) else $error("value not in low bytes");
  property p_sdo_func; s_sdo |-> dec_func_out == 4'hC; endproperty
  a_sdo_func: assert property (p_sdo_func) else $error("request code wrong");
  property p_target; dec_valid_out && dec_target_out |-> dec_index_out == 16'h607A
    && dec_area_out == 3'h3; endproperty
  a_target: assert property (p_target) else $error("target flag wrong");
  property p_comm; s_sdo ##0 (dec_index_out inside {[16'h0001:16'h1FFF]}) |->
    dec_area_out == 3'h1; endproperty
  a_comm: assert property (p_comm) else $error("comm area wrong");
  property p_prof; s_sdo ##0 (dec_index_out inside {[16'h6000:16'hBFFF]}) |->
    dec_area_out == (dec_index_out < 16'hA000 ? 3'h3 : 3'h4); endproperty
  a_prof: assert property (p_prof) else $error("profile area wrong");
  property p_fixed; $past(rx_ready_out) |-> $stable(node_id_out) && $stable(bit_rate_out);
  endproperty
  a_fixed: assert property (p_fixed) else $error("switch value changed");
  property p_sdo_id; rx_ready_out |-> sdo_tx_id_out == 11'h580 + node_id_out; endproperty
  a_sdo_id: assert property (p_sdo_id) else $error("response id wrong");
endmodule
bind cob_id_decode cob_id_monitor u_mon (.clock_in, .rst_in, .rx_ready_out, .dec_valid_out,
  .dec_ready_in, .dec_func_out, .dec_len_out, .dec_data_out, .dec_sdo_out, .dec_index_out,
  .dec_area_out, .dec_target_out, .tx_valid_out, .tx_ready_in, .tx_len_out, .tx_data_out,
  .node_id_out, .bit_rate_out, .sdo_tx_id_out);
`default_nettype wire

//--- sim/can_ctrl_model.sv
/*
  Bus controller model taking frames offered by the node.
  Assumes the node holds each frame until accepted.
*/
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Frame offer
  input wire logic slow_in,
  output logic tx_ready_out
);
  integer seed = 32'h0EF3;
  // Random acceptance, one cycle in four when slow, else one in two
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= slow_in ? (($random(seed) & 3) == 0) : (($random(seed) & 1) == 1);
    end
  end
endmodule
`default_nettype wire

//--- sim/cob_id_decode_tb.sv
/*
  Self-checking bench for cob_id_decode: queued expectations, monitors.
  Assumes the controller model on the transmit side.
*/
`timescale 1ns/1ps
`default_nettype none
module cob_id_decode_tb;
  logic clock_in, rst_in, rx_valid_in, rx_ext_in, dec_ready_in, tx_ready_in, slow, hold;
  logic [6:0] node_sw_in, node_id_out;
  logic [2:0] rate_sw_in, bit_rate_out, dec_area_out;
  logic [10:0] rx_id_in, tx_id_out, sdo_tx_id_out;
  logic [3:0] rx_len_in, dec_func_out, dec_len_out, tx_len_out;
  logic [63:0] rx_data_in, dec_data_out, tx_data_out;
  logic [1:0] tx_req_in, tx_busy_out;
  logic [21:0] tx_id_in;
  logic [31:0] tx_value0_in, tx_value1_in;
  logic [15:0] inhibit0_in, dec_index_out;
  logic rx_ready_out, dec_valid_out, dec_sdo_out, dec_target_out, tx_valid_out;
  logic [92:0] rxq[$];
  logic [92:0] txq[$];
  integer seed = 32'h0EF3;
  int miscompares = 0, num_checks = 0, cyc = 0, last0 = -9999, r;
  logic [15:0] idx[10] = '{16'h0000, 16'h0001, 16'h1FFF, 16'h2000, 16'h6000, 16'h607A,
    16'h9FFF, 16'hA000, 16'hBFFF, 16'hC000};
  cob_id_decode dut (.clock_in, .rst_in, .node_sw_in, .rate_sw_in, .rx_valid_in, .rx_id_in,
    .rx_ext_in, .rx_len_in, .rx_data_in, .rx_ready_out, .dec_valid_out, .dec_ready_in,
    .dec_func_out, .dec_len_out, .dec_data_out, .dec_sdo_out, .dec_index_out, .dec_area_out,
    .dec_target_out, .tx_req_in, .tx_id_in, .tx_value0_in, .tx_value1_in,
    .tx_len_in(6'h24), .inhibit0_in, .inhibit1_in(16'h0000), .tx_busy_out, .tx_valid_out,
    .tx_ready_in, .tx_id_out, .tx_len_out, .tx_data_out, .node_id_out, .bit_rate_out,
    .sdo_tx_id_out);
  can_ctrl_model partner (.clock_in, .rst_in, .slow_in(slow), .tx_ready_out(tx_ready_in));
  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input logic [92:0] got, input logic [92:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] area(input logic [15:0] i);
    area = i == 0 ? 3'h0 : i < 16'h2000 ? 3'h1 : i < 16'h6000 ? 3'h2 :
      i < 16'hA000 ? 3'h3 : i < 16'hC000 ? 3'h4 : 3'h5;
  endfunction
  task automatic send_rx(input logic [10:0] id, input logic ext, input logic [3:0] len,
      input logic [63:0] d);
    logic [15:0] ix;
    ix = id == 11'h670 ? d[23:8] : 16'h0000;
    @(posedge clock_in);
    rx_valid_in <= 1'b1;
    rx_id_in <= id;
    rx_ext_in <= ext;
    rx_len_in <= len;
    rx_data_in <= d;
    do @(posedge clock_in); while (rx_ready_out !== 1'b1);
    rx_valid_in <= 1'b0;
    if (!ext && (id[6:0] == 7'h70 || id[6:0] == 7'h00)) rxq.push_back({id[10:7],
      len > 8 ? 4'h8 : len, d, id == 11'h670, ix, area(ix), ix == 16'h607A});
  endtask
  task automatic fire(input logic [1:0] m, input logic [10:0] i0, i1, input logic [31:0] v);
    @(posedge clock_in);
    tx_req_in <= m;
    tx_id_in <= {i1, i0};
    // Only a requested slot's value changes; a waiting slot keeps its own
    if (m[0]) tx_value0_in <= v;
    if (m[1]) tx_value1_in <= ~v;
    @(posedge clock_in);
    tx_req_in <= 2'b00;
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < n && rxq.size() + txq.size() > 0; i++) @(posedge clock_in);
  endtask
  task automatic end_of_test;
    $display("num_checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // --------------------------------
  // Clock, stall and output monitors
  // --------------------------------
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    dec_ready_in <= !hold && (($random(seed) & 1) == 1);
    if (dec_valid_out && dec_ready_in) check({dec_func_out, dec_len_out, dec_data_out,
      dec_sdo_out, dec_index_out, dec_area_out, dec_target_out},
      rxq.size() ? rxq.pop_front() : 'x);
    if (tx_valid_out && tx_ready_in) begin
      check({tx_busy_out, tx_id_out, tx_len_out, tx_data_out},
        txq.size() ? txq.pop_front() : 'x);
      if (tx_busy_out[0]) check(cyc - last0 >= 1000, 1'b1);
      if (tx_busy_out[0]) last0 = cyc;
    end
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    end_of_test;
  end
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {rst_in, hold, slow} = 3'b100;
    {rx_valid_in, rx_ext_in, tx_req_in} = 4'h0;
    {rx_id_in, rx_len_in, rx_data_in, tx_id_in, tx_value0_in, tx_value1_in} = '0;
    node_sw_in = 7'h70;
    rate_sw_in = 3'h5;
    inhibit0_in = 16'h0001;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      send_rx({r[11:8], r[3:2] == 0 ? 7'h70 : r[3:2] == 1 ? 7'h00 : r[3:2] == 2 ? 7'h71 :
        r[18:12]}, r[0] & r[1], r[7:4], {$random(seed), $random(seed)});
    end
    foreach (idx[i]) send_rx(11'h670, 1'b0, 4'h8, {40'h0, idx[i], 8'h40});
    // Empty output stage and buffer so exactly 17 frames fit
    drain(400);
    hold <= 1'b1;
    repeat (17) send_rx(11'h670, 1'b0, 4'h4, {$random(seed), $random(seed)});
    repeat (3) @(posedge clock_in);
    check(rx_ready_out, 1'b0);
    hold <= 1'b0;
    slow <= 1'b1;
    drain(400);
    fire(2'b11, 11'h1F0, 11'h181, 32'h89ABCDEF);
    txq.push_back({2'b10, 11'h181, 4'h4, 32'h0, ~32'h89ABCDEF});
    txq.push_back({2'b01, 11'h1F0, 4'h4, 32'h0, 32'h89ABCDEF});
    drain(400);
    fire(2'b01, 11'h1F0, 11'h181, 32'h01234567);
    fire(2'b10, 11'h1F0, 11'h181, 32'h00C0FFEE);
    txq.push_back({2'b10, 11'h181, 4'h4, 32'h0, ~32'h00C0FFEE});
    txq.push_back({2'b01, 11'h1F0, 4'h4, 32'h0, 32'h01234567});
    drain(2000);
    node_sw_in <= 7'h11;
    rate_sw_in <= 3'h2;
    send_rx(11'h611, 1'b0, 4'h2, 64'h55);
    // Give a wrongly accepted frame time to surface at the output
    repeat (20) @(posedge clock_in);
    check({node_id_out, bit_rate_out, sdo_tx_id_out}, {7'h70, 3'h5, 11'h5F0});
    check(rxq.size() + txq.size(), 0);
    end_of_test;
  end
endmodule
`default_nettype wire
